// ### src/dcp_top.sv
/*
  DAC channel protection and power control with AXI4-Lite registers.
  Assumes detector and supply inputs are asynchronous levels and the
  bus master keeps at most one write and one read outstanding.
*/
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module dcp_top
  import dcp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        supply_stable,
  input  wire logic [1:0]  overcurrent_detect,
  input  wire logic        overtemp_detect,
  output logic [1:0]       amplifier_output_gate,
  output logic [1:0]       output_ground_switch,
  output logic             current_clamp_enable,
  output logic [15:0]      dac_data_a,
  output logic [15:0]      dac_data_b,
  output logic             irq
);
  logic [1:0]         oc_sync;
  logic               ot_sync;
  logic               supply_sync;
  logic [1:0]         channel_power_up_q;
  logic [1:0]         overcurrent_flag_q;
  logic               thermal_alert_q;
  logic [3:0]         control_q;
  logic [1:0]         data_written_q;
  logic [DCP_IRQ_W-1:0] irq_stat_q;
  logic [DCP_IRQ_W-1:0] irq_mask_q;
  logic [1:0]         oc_prev_q;
  logic               ot_prev_q;
  logic               aw_held_q;
  logic               w_held_q;
  logic [7:0]         awaddr_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic               wr_go;
  logic               wr_hit;
  logic               thermal_event;
  logic [1:0]         auto_down;
  logic [DCP_IRQ_W-1:0] irq_events;
  logic [31:0]        power_word;
  logic [31:0]        rd_word;
  logic               rd_hit;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == DCP_OFF_POWER) || (a == DCP_OFF_CONTROL) ||
             (a == DCP_OFF_DATA_A) || (a == DCP_OFF_DATA_B) ||
             (a == DCP_OFF_IRQ_STAT) || (a == DCP_OFF_IRQ_MASK) ||
             (a == DCP_OFF_SUPPLY);
  endfunction

  dcp_sync #(.W(4)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({supply_stable, overtemp_detect, overcurrent_detect}),
    .sync_out ({supply_sync, ot_sync, oc_sync})
  );

  // Write channel acceptance, address and data in either order
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign wr_go  = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_hit = wr_go && mapped(awaddr_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_held_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      else if (wr_go)
        w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= DCP_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? DCP_RESP_OKAY : DCP_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Fault events
  assign thermal_event = control_q[DCP_TSD_EN_BIT] && ot_sync;
  assign auto_down = control_q[DCP_CLAMP_BIT] ? 2'b00 : oc_sync;
  assign current_clamp_enable = control_q[DCP_CLAMP_BIT];

  // Power-up bits; faults win over a host write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      channel_power_up_q <= 2'b00;
    else
    begin
      if (wr_hit && awaddr_q == DCP_OFF_POWER && wstrb_q[0])
      begin
        channel_power_up_q[0] <= wdata_q[DCP_PU_A_BIT];
        channel_power_up_q[1] <= wdata_q[DCP_PU_B_BIT];
      end
      if (thermal_event)
        channel_power_up_q <= 2'b00;
      for (int i = 0; i < DCP_NCH; i++)
        if (auto_down[i])
          channel_power_up_q[i] <= 1'b0;
    end
  end

  // Read-only alert flags, never written by the host
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      overcurrent_flag_q <= 2'b00;
      thermal_alert_q    <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < DCP_NCH; i++)
        if (control_q[DCP_CLAMP_BIT])
          overcurrent_flag_q[i] <= oc_sync[i];
        else if (oc_sync[i])
          overcurrent_flag_q[i] <= 1'b1;
        else if (channel_power_up_q[i])
          overcurrent_flag_q[i] <= 1'b0;
      if (thermal_event)
        thermal_alert_q <= 1'b1;
      else if (!ot_sync && channel_power_up_q != 2'b00)
        thermal_alert_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      control_q <= DCP_CONTROL_RST;
    else if (wr_hit && awaddr_q == DCP_OFF_CONTROL && wstrb_q[0])
      control_q <= wdata_q[3:0];
  end

  // DAC data words; a write marks the channel valid
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dac_data_a     <= 16'h0000;
      dac_data_b     <= 16'h0000;
      data_written_q <= 2'b00;
    end
    else if (wr_hit && awaddr_q == DCP_OFF_DATA_A)
    begin
      dac_data_a        <= wdata_q[15:0];
      data_written_q[0] <= 1'b1;
    end
    else if (wr_hit && awaddr_q == DCP_OFF_DATA_B)
    begin
      dac_data_b        <= wdata_q[15:0];
      data_written_q[1] <= 1'b1;
    end
  end

  // Interrupts: rising-edge events, set wins over write-one clear
  assign irq_events = {thermal_event && !ot_prev_q,
                       oc_sync[1] && !oc_prev_q[1],
                       oc_sync[0] && !oc_prev_q[0]};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      oc_prev_q  <= 2'b00;
      ot_prev_q  <= 1'b0;
    end
    else
    begin
      oc_prev_q <= oc_sync;
      ot_prev_q <= thermal_event;
      if (wr_hit && awaddr_q == DCP_OFF_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~wdata_q[DCP_IRQ_W-1:0]) | irq_events;
      else
        irq_stat_q <= irq_stat_q | irq_events;
      if (wr_hit && awaddr_q == DCP_OFF_IRQ_MASK)
        irq_mask_q <= wdata_q[DCP_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  genvar g;
  generate
    for (g = 0; g < DCP_NCH; g++)
    begin : g_ch
      dcp_channel u_ch (
        .aclk                  (aclk),
        .aresetn               (aresetn),
        .supply_good           (supply_sync),
        .data_written          (data_written_q[g]),
        .power_up              (channel_power_up_q[g]),
        .amplifier_output_gate (amplifier_output_gate[g]),
        .output_ground_switch  (output_ground_switch[g])
      );
    end
  endgenerate

  // Read path
  always_comb
  begin
    power_word = 32'h0000_0000;
    power_word[DCP_PU_A_BIT]   = channel_power_up_q[0];
    power_word[DCP_PU_B_BIT]   = channel_power_up_q[1];
    power_word[DCP_TALERT_BIT] = thermal_alert_q;
    power_word[DCP_OC_A_BIT]   = overcurrent_flag_q[0];
    power_word[DCP_OC_B_BIT]   = overcurrent_flag_q[1];
  end

  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      DCP_OFF_POWER:    rd_word = power_word;
      DCP_OFF_CONTROL:  rd_word = {28'h0000000, control_q};
      DCP_OFF_DATA_A:   rd_word = {16'h0000, dac_data_a};
      DCP_OFF_DATA_B:   rd_word = {16'h0000, dac_data_b};
      DCP_OFF_IRQ_STAT: rd_word = {29'h0000000, irq_stat_q};
      DCP_OFF_IRQ_MASK: rd_word = {29'h0000000, irq_mask_q};
      DCP_OFF_SUPPLY:   rd_word = {31'h00000000, supply_sync};
      default:          rd_hit  = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= DCP_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? DCP_RESP_OKAY : DCP_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

// ### pkg/dcp_pkg.sv
/*
  Constants, register layout and state encodings of the DAC channel
  protection and power control block.
  Assumes an AXI4-Lite master with 32-bit data and one 20 MHz clock.
*/
// Contract
// - Outputs grounded until supplies good, data written
// - Channels power down independently, reset powered down
// - Powered down: ground switch on, amplifier off
// - Clamp enable selects limit or auto power-down
// - Clamp mode: flag follows short, channel stays
// - Auto mode: short powers down, flags, clears power-up
// - Thermal shutdown disabled after reset
// - Enabled overtemperature shuts channels, sets alert
// - Power control register code 010, bit layout
// - Control register code 011 address 001 layout
// - Alert bits read-only; thermal event downs both
package dcp_pkg;
  localparam int          DCP_NCH          = 2;
  localparam logic [2:0]  DCP_SEL_POWER    = 3'h2;
  localparam logic [2:0]  DCP_SEL_CONTROL  = 3'h3;
  localparam logic [2:0]  DCP_CTRL_ADDR    = 3'h1;
  // Byte addresses on the AXI4-Lite bus
  localparam logic [7:0]  DCP_OFF_POWER    = 8'h08;
  localparam logic [7:0]  DCP_OFF_CONTROL  = 8'h0c;
  localparam logic [7:0]  DCP_OFF_DATA_A   = 8'h00;
  localparam logic [7:0]  DCP_OFF_DATA_B   = 8'h04;
  localparam logic [7:0]  DCP_OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0]  DCP_OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0]  DCP_OFF_SUPPLY   = 8'h18;
  // Power control register bit positions
  localparam int          DCP_PU_A_BIT     = 0;
  localparam int          DCP_PU_B_BIT     = 2;
  localparam int          DCP_TALERT_BIT   = 5;
  localparam int          DCP_OC_A_BIT     = 7;
  localparam int          DCP_OC_B_BIT     = 9;
  // Control register bit positions
  localparam int          DCP_SDO_DIS_BIT  = 0;
  localparam int          DCP_CLR_SEL_BIT  = 1;
  localparam int          DCP_CLAMP_BIT    = 2;
  localparam int          DCP_TSD_EN_BIT   = 3;
  localparam logic [3:0]  DCP_CONTROL_RST  = 4'h4;
  // Interrupt status layout
  localparam int          DCP_IRQ_OC_A     = 0;
  localparam int          DCP_IRQ_OC_B     = 1;
  localparam int          DCP_IRQ_THERM    = 2;
  localparam int          DCP_IRQ_W        = 3;
  localparam logic [1:0]  DCP_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  DCP_RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    DCP_CH_CLAMPED = 3'b001,
    DCP_CH_OFF     = 3'b010,
    DCP_CH_ON      = 3'b100
  } dcp_ch_state_type;
endpackage

// ### src/dcp_sync.sv
/*
  Two-flop synchroniser for asynchronous detector levels.
  Assumes inputs are quasi-static levels from the analog side.
*/
`timescale 1ns/1ps
module dcp_sync
  import dcp_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ### src/dcp_channel.sv
/*
  One DAC channel power state machine with output switch control.
  Assumes synchronised power-up and supply inputs on the same clock.
*/
`timescale 1ns/1ps
module dcp_channel
  import dcp_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic supply_good,
  input  wire logic data_written,
  input  wire logic power_up,
  output logic      amplifier_output_gate,
  output logic      output_ground_switch
);
  dcp_ch_state_type state_q;
  dcp_ch_state_type state_d;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      DCP_CH_CLAMPED:
        if (supply_good && data_written && power_up)
          state_d = DCP_CH_ON;
        else if (supply_good && data_written)
          state_d = DCP_CH_OFF;
      DCP_CH_OFF:
        if (!supply_good)
          state_d = DCP_CH_CLAMPED;
        else if (power_up)
          state_d = DCP_CH_ON;
      DCP_CH_ON:
        if (!supply_good)
          state_d = DCP_CH_CLAMPED;
        else if (!power_up)
          state_d = DCP_CH_OFF;
      default:
        state_d = DCP_CH_CLAMPED;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= DCP_CH_CLAMPED;
    else
      state_q <= state_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      amplifier_output_gate <= 1'b0;
      output_ground_switch  <= 1'b1;
    end
    else
    begin
      amplifier_output_gate <= (state_d == DCP_CH_ON);
      output_ground_switch  <= (state_d != DCP_CH_ON);
    end
  end
endmodule

// ### test/dcp_analog_model.sv
/*
  Analog front end model: short and overheat detectors.
  Assumes the bench sets the load and die temperature levels.
*/
`timescale 1ns/1ps
module dcp_analog_model
(
  input  wire logic [1:0] load_short,
  input  wire logic       hot,
  input  wire logic [1:0] amplifier_output_gate,
  output logic      [1:0] overcurrent_detect,
  output logic            overtemp_detect
);
  // Short only seen while amplifier drives pin
  assign overcurrent_detect = load_short & amplifier_output_gate;
  assign overtemp_detect    = hot;
endmodule

// ### test/dcp_top_chk.sv
/*
  Concurrent checks on the top ports of the protection block.
  Assumes one clock and a synchronous active low reset.
*/
`timescale 1ns/1ps
module dcp_top_chk
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic        supply_stable,
  input  wire logic [1:0]  overcurrent_detect,
  input  wire logic        overtemp_detect,
  input  wire logic [1:0]  amplifier_output_gate,
  input  wire logic [1:0]  output_ground_switch,
  input  wire logic        current_clamp_enable,
  input  wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_reset_state: assert property ($rose(aresetn) |->
    output_ground_switch == 2'h3 && amplifier_output_gate == 2'h0
    && current_clamp_enable && !irq) else $error("bad reset state");
  chk_gate_ground: assert property (
    amplifier_output_gate == ~output_ground_switch)
    else $error("gate and ground switch overlap");
  chk_supply_gate: assert property (
    !supply_stable [*5] |-> amplifier_output_gate == 2'h0)
    else $error("amplifier on without supply");
  chk_auto_down: assert property (
    $rose(overcurrent_detect[0]) && !current_clamp_enable
    |-> amplifier_output_gate[0] [*2] ##[1:4] !amplifier_output_gate[0])
    else $error("auto power down timing");
  chk_clamp_stays: assert property (
    $rose(overcurrent_detect[1]) && amplifier_output_gate[1] ##1
    (current_clamp_enable && supply_stable && !overtemp_detect
    && !s_axi_bvalid) [*5] |-> amplifier_output_gate[1])
    else $error("clamp mode dropped channel");
  chk_chan_indep: assert property (
    $rose(overcurrent_detect[0]) && amplifier_output_gate[1] ##1
    (!overcurrent_detect[1] && supply_stable && !overtemp_detect
    && !s_axi_bvalid) [*5] |-> amplifier_output_gate[1])
    else $error("other channel disturbed");
  chk_write_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  chk_read_block: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  cover property ($rose(irq));
  cover property ($fell(amplifier_output_gate[0]));
  cover property (s_axi_rvalid && s_axi_rdata[5]);
endmodule
bind dcp_top dcp_top_chk chk
(
  .aclk                  (aclk),
  .aresetn               (aresetn),
  .s_axi_awready         (s_axi_awready),
  .s_axi_wready          (s_axi_wready),
  .s_axi_bvalid          (s_axi_bvalid),
  .s_axi_arready         (s_axi_arready),
  .s_axi_rvalid          (s_axi_rvalid),
  .s_axi_rdata           (s_axi_rdata),
  .supply_stable         (supply_stable),
  .overcurrent_detect    (overcurrent_detect),
  .overtemp_detect       (overtemp_detect),
  .amplifier_output_gate (amplifier_output_gate),
  .output_ground_switch  (output_ground_switch),
  .current_clamp_enable  (current_clamp_enable),
  .irq                   (irq)
);

// ### test/dcp_top_tb.sv
/*
  Register level bench of the protection block.
  Assumes an AXI4-Lite master and the analog front end model.
*/
`timescale 1ns/1ps
module dcp_top_tb
  import dcp_pkg::*;
;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  s_axi_awaddr = '0;
  logic [7:0]  s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0;
  logic        s_axi_wvalid = 0;
  logic        s_axi_bready = 0;
  logic        s_axi_arvalid = 0;
  logic        s_axi_rready = 0;
  logic        supply_stable = 0;
  logic [1:0]  load = '0;
  logic        hot = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, current_clamp_enable, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, overcurrent_detect;
  logic [1:0]  amplifier_output_gate, output_ground_switch;
  logic        overtemp_detect;
  logic [31:0] s_axi_rdata;
  logic [15:0] dac_data_a, dac_data_b;
  int          failures = 0;
  int          total_checks = 0;
  always #25 aclk = ~aclk;
  dcp_top dut
  (
    .aclk                  (aclk),
    .aresetn               (aresetn),
    .s_axi_awaddr          (s_axi_awaddr),
    .s_axi_awvalid         (s_axi_awvalid),
    .s_axi_awready         (s_axi_awready),
    .s_axi_wdata           (s_axi_wdata),
    .s_axi_wstrb           (s_axi_wstrb),
    .s_axi_wvalid          (s_axi_wvalid),
    .s_axi_wready          (s_axi_wready),
    .s_axi_bresp           (s_axi_bresp),
    .s_axi_bvalid          (s_axi_bvalid),
    .s_axi_bready          (s_axi_bready),
    .s_axi_araddr          (s_axi_araddr),
    .s_axi_arvalid         (s_axi_arvalid),
    .s_axi_arready         (s_axi_arready),
    .s_axi_rdata           (s_axi_rdata),
    .s_axi_rresp           (s_axi_rresp),
    .s_axi_rvalid          (s_axi_rvalid),
    .s_axi_rready          (s_axi_rready),
    .supply_stable         (supply_stable),
    .overcurrent_detect    (overcurrent_detect),
    .overtemp_detect       (overtemp_detect),
    .amplifier_output_gate (amplifier_output_gate),
    .output_ground_switch  (output_ground_switch),
    .current_clamp_enable  (current_clamp_enable),
    .dac_data_a            (dac_data_a),
    .dac_data_b            (dac_data_b),
    .irq                   (irq)
  );
  dcp_analog_model fe
  (
    .load_short            (load),
    .hot                   (hot),
    .amplifier_output_gate (amplifier_output_gate),
    .overcurrent_detect    (overcurrent_detect),
    .overtemp_detect       (overtemp_detect)
  );
  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = DCP_RESP_OKAY);
    bit done;
    done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int i = 0; i < 40 && !done; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid)
      begin
        done = 1;
        s_axi_bready <= 0;
        cmp("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
      end
    end
    if (!done) cmp("write done", 1, 0);
    if (!done) complete_run();
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    bit done;
    done = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int i = 0; i < 40 && !done; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid)
      begin
        done = 1;
        s_axi_rready <= 0;
        cmp("rdata", e, s_axi_rdata);
        cmp("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
      end
    end
    if (!done) cmp("read done", 1, 0);
    if (!done) complete_run();
    @(posedge aclk);
  endtask
  task automatic outs(input logic [3:0] e);
    repeat (6) @(posedge aclk);
    cmp("gate_ground", {28'h0, e},
        {28'h0, amplifier_output_gate, output_ground_switch});
  endtask
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    outs(4'h3);
    rd(DCP_OFF_POWER, 32'h0, DCP_RESP_OKAY);
    rd(DCP_OFF_CONTROL, 32'h4, DCP_RESP_OKAY);
    wr(DCP_OFF_DATA_A, 32'h1234);
    wr(DCP_OFF_POWER, 32'h5);
    outs(4'h3);
    supply_stable <= 1;
    outs(4'h6);
    rd(DCP_OFF_SUPPLY, 32'h1, DCP_RESP_OKAY);
    wr(DCP_OFF_DATA_B, 32'h0abc);
    outs(4'hc);
    cmp("dac_data_a", 32'h1234, {16'h0, dac_data_a});
    cmp("dac_data_b", 32'h0abc, {16'h0, dac_data_b});
    rd(DCP_OFF_DATA_A, 32'h1234, DCP_RESP_OKAY);
    wr(DCP_OFF_POWER, 32'h1);
    outs(4'h6);
    wr(DCP_OFF_POWER, 32'h5);
    load <= 2'h2;
    outs(4'hc);
    rd(DCP_OFF_POWER, 32'h205, DCP_RESP_OKAY);
    cmp("irq masked", 0, {31'h0, irq});
    load <= 2'h0;
    outs(4'hc);
    rd(DCP_OFF_POWER, 32'h5, DCP_RESP_OKAY);
    wr(DCP_OFF_IRQ_MASK, 32'h3);
    cmp("irq set", 1, {31'h0, irq});
    wr(DCP_OFF_IRQ_STAT, 32'h2);
    cmp("irq cleared", 0, {31'h0, irq});
    wr(DCP_OFF_CONTROL, 32'h0);
    load <= 2'h1;
    outs(4'h9);
    rd(DCP_OFF_POWER, 32'h84, DCP_RESP_OKAY);
    cmp("irq fault", 1, {31'h0, irq});
    load <= 2'h0;
    wr(DCP_OFF_IRQ_STAT, 32'h1);
    wr(DCP_OFF_POWER, 32'h5);
    outs(4'hc);
    rd(DCP_OFF_POWER, 32'h5, DCP_RESP_OKAY);
    cmp("irq idle", 0, {31'h0, irq});
    wr(DCP_OFF_POWER, 32'h2a5);
    rd(DCP_OFF_POWER, 32'h5, DCP_RESP_OKAY);
    hot <= 1;
    outs(4'hc);
    wr(DCP_OFF_CONTROL, 32'h8);
    rd(DCP_OFF_CONTROL, 32'h8, DCP_RESP_OKAY);
    outs(4'h3);
    rd(DCP_OFF_POWER, 32'h20, DCP_RESP_OKAY);
    hot <= 0;
    outs(4'h3);
    wr(DCP_OFF_POWER, 32'h5);
    outs(4'hc);
    rd(DCP_OFF_POWER, 32'h5, DCP_RESP_OKAY);
    s_axi_wstrb <= 4'he;
    wr(DCP_OFF_POWER, 32'h0);
    s_axi_wstrb <= 4'hf;
    rd(DCP_OFF_POWER, 32'h5, DCP_RESP_OKAY);
    rd(8'h1c, 32'h0, DCP_RESP_SLVERR);
    wr(8'h1c, 32'h0, DCP_RESP_SLVERR);
    complete_run();
  end
endmodule
